// >>> gpeio_pkg.sv
// package: register map, field layout and carrier types for the event block
package gpeio_pkg;
   localparam int         ADDR_W          = 8;
   localparam int         DATA_W          = 16;
   localparam int         PIN_N           = 5;
   localparam int         FUNC_W          = 3;
   localparam logic [2:0] FUNC_OWNER      = 3'h0;
   localparam logic [7:0] OFF_EVT_STATUS  = 8'hA8;
   localparam logic [7:0] OFF_EVT_ENABLE  = 8'hAA;
   localparam logic [7:0] OFF_PIN_INPUT   = 8'hAC;
   localparam logic [7:0] OFF_PIN_OUTPUT  = 8'hAE;
   localparam logic [15:0] EVT_WR_MASK    = 16'hC91F;
   localparam logic [15:0] PIN_WR_MASK    = 16'h001F;
   localparam logic [15:0] RST_ZERO       = 16'h0000;
   localparam int         BIT_SOCK0_VIDEO = 15;
   localparam int         BIT_SOCK1_VIDEO = 14;
   localparam int         BIT_POWER       = 11;
   localparam int         BIT_PROG_VOLT   = 8;
   localparam int         BIT_PIN_LO      = 0;

   // one configuration access
   typedef struct packed {
      logic                 rd;
      logic                 wr;
      logic [FUNC_W-1:0]    func;
      logic [ADDR_W-1:0]    addr;
      logic [1:0]           be;
      logic [DATA_W-1:0]    wdata;
   } gpeio_cfg_req_s;

   // socket-side sources of events, all from logic on mclk
   typedef struct packed {
      logic sock0_video_on;
      logic sock1_video_on;
      logic power_change;
      logic prog_volt_change;
   } gpeio_src_s;

   // per-terminal role selection from the terminal routing logic
   typedef struct packed {
      logic [PIN_N-1:0] input_role;
      logic [PIN_N-1:0] output_role;
      logic             event_route_any;
   } gpeio_route_s;
endpackage

// >>> gpeio_sync.sv
// two-stage synchroniser with change detect on the settled stage
`timescale 1ns/100ps
module gpeio_sync #(
   parameter int WIDTH = 5
) (
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] changed
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] prev_q;
   logic             primed_q;

   initial begin
      if (WIDTH < 1) $error("gpeio_sync width must be positive");
   end

   always_ff @(posedge mclk) begin
      if (reset)
      begin
         meta_q   <= '0;
         level_q  <= '0;
         prev_q   <= '0;
         primed_q <= 1'b0;
      end
      else if (clk_en)
      begin
         meta_q   <= async_in;
         level_q  <= meta_q;
         prev_q   <= level_q;
         primed_q <= 1'b1;
      end
   end

   assign level = level_q;
   // mask covers only the first cycle after reset; an input high from reset still flags one change as it reaches level_q
   assign changed = primed_q ? (level_q ^ prev_q) : '0;
endmodule // gpeio_sync

// >>> gpeio_edge.sv
// change detector for same-domain control levels
`timescale 1ns/100ps
module gpeio_edge #(
   parameter int WIDTH = 2
) (
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] changed
);
   logic [WIDTH-1:0] prev_q;
   logic             primed_q;

   initial begin
      if (WIDTH < 1) $error("gpeio_edge width must be positive");
   end

   always_ff @(posedge mclk) begin
      if (reset)
      begin
         prev_q   <= '0;
         primed_q <= 1'b0;
      end
      else if (clk_en)
      begin
         prev_q   <= level;
         primed_q <= 1'b1;
      end
   end

   assign changed = primed_q ? (level ^ prev_q) : '0;
endmodule // gpeio_edge

// >>> gpeio_top.sv
// general-purpose event and terminal i/o block behind configuration space
`timescale 1ns/100ps
module gpeio_top #(
   parameter int PIN_N = gpeio_pkg::PIN_N
) (
   input  wire logic                          mclk,
   input  wire logic                          reset,
   input  wire logic                          clk_en,
   input  wire gpeio_pkg::gpeio_cfg_req_s     cfg_req,
   output logic [gpeio_pkg::DATA_W-1:0]       cfg_rdata,
   output logic                               cfg_rvalid,
   output logic                               cfg_hit,
   input  wire gpeio_pkg::gpeio_src_s         src,
   input  wire gpeio_pkg::gpeio_route_s       route,
   input  wire logic [PIN_N-1:0]              multi_pin_in,
   output logic      [PIN_N-1:0]              multi_pin_out,
   output logic      [PIN_N-1:0]              multi_pin_oe,
   output logic                               general_event_out_n,
   output logic                               general_event_oe
);
   localparam int DW = gpeio_pkg::DATA_W;

   logic [DW-1:0]    status_q;
   logic [DW-1:0]    status_d;
   logic [DW-1:0]    enable_q;
   logic [PIN_N-1:0] out_level_q;
   logic [PIN_N-1:0] pin_level;
   logic [PIN_N-1:0] pin_changed;
   logic [1:0]       video_changed;
   logic [DW-1:0]    evt_raw;
   logic [DW-1:0]    wr_data;
   logic [DW-1:0]    be_mask;
   logic             sel_f0;
   logic             wr_status;
   logic             wr_enable;
   logic             wr_output;
   logic [DW-1:0]    rd_mux;
   logic             rd_known;

   initial begin
      if (PIN_N != gpeio_pkg::PIN_N)
         $error("gpeio_top serves exactly five terminals");
   end

   // terminal inputs pass two flops before change detection
   gpeio_sync #(
      .WIDTH (PIN_N)
   ) u_pin_sync (
      .mclk     (mclk),
      .reset    (reset),
      .clk_en   (clk_en),
      .async_in (multi_pin_in),
      .level    (pin_level),
      .changed  (pin_changed)
   );

   gpeio_edge #(
      .WIDTH (2)
   ) u_video_edge (
      .mclk    (mclk),
      .reset   (reset),
      .clk_en  (clk_en),
      .level   ({src.sock0_video_on, src.sock1_video_on}),
      .changed (video_changed)
   );

   // event vector in status-bit layout
   always_comb begin
      evt_raw = '0;
      evt_raw[gpeio_pkg::BIT_SOCK0_VIDEO] = video_changed[1];
      evt_raw[gpeio_pkg::BIT_SOCK1_VIDEO] = video_changed[0];
      evt_raw[gpeio_pkg::BIT_POWER]       = src.power_change;
      evt_raw[gpeio_pkg::BIT_PROG_VOLT]   = src.prog_volt_change;
      // a level change counts only on a terminal set up as an input
      evt_raw[gpeio_pkg::BIT_PIN_LO +: PIN_N] =
         pin_changed & route.input_role;
   end

   // access decode; other functions see nothing here
   assign sel_f0    = (cfg_req.func == gpeio_pkg::FUNC_OWNER);
   assign be_mask   = {{(DW/2){cfg_req.be[1]}}, {(DW/2){cfg_req.be[0]}}};
   assign wr_data   = cfg_req.wdata & be_mask;
   assign wr_status = cfg_req.wr & sel_f0 &
                      (cfg_req.addr == gpeio_pkg::OFF_EVT_STATUS);
   assign wr_enable = cfg_req.wr & sel_f0 &
                      (cfg_req.addr == gpeio_pkg::OFF_EVT_ENABLE);
   assign wr_output = cfg_req.wr & sel_f0 &
                      (cfg_req.addr == gpeio_pkg::OFF_PIN_OUTPUT);

   // set wins over a same-cycle write-one-to-clear
   always_comb begin
      status_d = status_q;
      if (wr_status)
         status_d = status_d & ~wr_data;
      status_d = (status_d | evt_raw) & gpeio_pkg::EVT_WR_MASK;
   end

   always_ff @(posedge mclk) begin
      if (reset)
         status_q <= gpeio_pkg::RST_ZERO;
      else if (clk_en)
         status_q <= status_d;
   end

   always_ff @(posedge mclk) begin
      if (reset)
         enable_q <= gpeio_pkg::RST_ZERO;
      else if (clk_en && wr_enable)
         enable_q <= (enable_q & ~(be_mask & gpeio_pkg::EVT_WR_MASK)) |
                     (wr_data & gpeio_pkg::EVT_WR_MASK);
   end

   always_ff @(posedge mclk) begin
      if (reset)
         out_level_q <= gpeio_pkg::RST_ZERO[PIN_N-1:0];
      else if (clk_en && wr_output && cfg_req.be[0])
         out_level_q <= cfg_req.wdata[PIN_N-1:0];
   end

   // read mux; reserved bits are zero by construction
   always_comb begin
      rd_mux   = '0;
      rd_known = sel_f0;
      case (cfg_req.addr)
         gpeio_pkg::OFF_EVT_STATUS: rd_mux = status_q;
         gpeio_pkg::OFF_EVT_ENABLE: rd_mux = enable_q;
         gpeio_pkg::OFF_PIN_INPUT:  rd_mux[PIN_N-1:0] = pin_level;
         gpeio_pkg::OFF_PIN_OUTPUT: rd_mux[PIN_N-1:0] = out_level_q;
         default:                   rd_known = 1'b0;
      endcase
      if (!sel_f0)
         rd_mux = '0;
   end

   always_ff @(posedge mclk) begin
      if (reset)
      begin
         cfg_rdata  <= '0;
         cfg_rvalid <= 1'b0;
         cfg_hit    <= 1'b0;
      end
      else if (clk_en)
      begin
         cfg_rvalid <= cfg_req.rd;
         cfg_hit    <= (cfg_req.rd | cfg_req.wr) & rd_known;
         cfg_rdata  <= cfg_req.rd ? rd_mux : '0;
      end
   end

   // pin drivers registered so outputs come straight from flops
   always_ff @(posedge mclk) begin
      if (reset)
      begin
         multi_pin_out <= '0;
         multi_pin_oe  <= '0;
      end
      else if (clk_en)
      begin
         multi_pin_out <= out_level_q & route.output_role;
         multi_pin_oe  <= route.output_role;
      end
   end

   // low while event_route_any is set and any enabled status bit pends; one cycle behind status
   always_ff @(posedge mclk) begin
      if (reset)
      begin
         general_event_out_n <= 1'b1;
         general_event_oe    <= 1'b0;
      end
      else if (clk_en)
      begin
         general_event_out_n <= ~(route.event_route_any &
                                  (|(status_q & enable_q)));
         general_event_oe    <= route.event_route_any;
      end
   end
endmodule // gpeio_top

// >>> gpeio_chk.sv
// checker: port-level timing of the event and terminal block
`timescale 1ns/100ps
module gpeio_chk #(
   parameter int PIN_N = 5
) (
   input wire logic                      mclk,
   input wire logic                      reset,
   input wire logic                      clk_en,
   input wire gpeio_pkg::gpeio_cfg_req_s cfg_req,
   input wire logic [15:0]               cfg_rdata,
   input wire logic                      cfg_rvalid,
   input wire logic                      cfg_hit,
   input wire gpeio_pkg::gpeio_src_s     src,
   input wire gpeio_pkg::gpeio_route_s   route,
   input wire logic [PIN_N-1:0]          multi_pin_in,
   input wire logic [PIN_N-1:0]          multi_pin_out,
   input wire logic [PIN_N-1:0]          multi_pin_oe,
   input wire logic                      general_event_out_n,
   input wire logic                      general_event_oe
);
   wire is_rd = cfg_req.rd && clk_en;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   chk_rd_answer: assert property (is_rd |=> cfg_rvalid)
      else $error("read not answered");
   chk_func_refused: assert property (is_rd && cfg_req.func != 3'h0
      |=> !cfg_hit && cfg_rdata == 16'h0000) else $error("func refused");
   chk_enable_reserved: assert property (is_rd && cfg_req.func == 3'h0
      && cfg_req.addr == 8'hAA |=> cfg_hit && (cfg_rdata & 16'h36E0) == 0)
      else $error("enable reserved bits");
   chk_pin_reserved: assert property (is_rd && (cfg_req.addr == 8'hAC
      || cfg_req.addr == 8'hAE) |=> cfg_rdata[15:5] == 11'h000)
      else $error("pin reserved bits");
   chk_event_route: assert property (clk_en
      |=> general_event_oe == $past(route.event_route_any))
      else $error("event enable vs route");
   chk_pin_role: assert property (clk_en
      |=> multi_pin_oe == $past(route.output_role))
      else $error("pin enable vs role");
   chk_pin_gated: assert property ((multi_pin_out & ~multi_pin_oe) == '0)
      else $error("pin driven without role");
   chk_event_held: assert property (!general_event_out_n && !cfg_req.wr
      && !$past(cfg_req.wr) && route.event_route_any |=> !general_event_out_n)
      else $error("event released early");
endmodule // gpeio_chk

bind gpeio_top gpeio_chk #(.PIN_N(PIN_N)) u_chk (.mclk(mclk), .reset(reset),
   .clk_en(clk_en), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
   .cfg_rvalid(cfg_rvalid), .cfg_hit(cfg_hit), .src(src), .route(route),
   .multi_pin_in(multi_pin_in), .multi_pin_out(multi_pin_out),
   .multi_pin_oe(multi_pin_oe), .general_event_out_n(general_event_out_n),
   .general_event_oe(general_event_oe));

// >>> gpeio_pins_model.sv
// model of the terminals and the pulled-up system event line
`timescale 1ns/100ps
module gpeio_pins_model (
   input  wire logic [4:0] ext_level,
   input  wire logic [4:0] drv_val,
   input  wire logic [4:0] drv_oe,
   input  wire logic       evt_n,
   input  wire logic       evt_oe,
   output logic      [4:0] pin_level,
   output logic            evt_line
);
   // a driven terminal wins over the outside level
   assign pin_level = (drv_oe & drv_val) | (~drv_oe & ext_level);
   // pull-up keeps the shared line idle when nothing drives it
   assign evt_line = evt_oe ? evt_n : 1'b1;
endmodule // gpeio_pins_model

// >>> tb_top.sv
// self-checking bench for the event and terminal block
`timescale 1ns/100ps
module tb_top;
   logic                      mclk;
   logic                      reset;
   logic                      clk_en;
   gpeio_pkg::gpeio_cfg_req_s req;
   gpeio_pkg::gpeio_src_s     src;
   gpeio_pkg::gpeio_route_s   route;
   logic [15:0]               rdata;
   logic                      rvalid;
   logic                      hit;
   logic [4:0]                pin_lvl;
   logic [4:0]                pin_in;
   logic [4:0]                pin_out;
   logic [4:0]                pin_oe;
   logic                      ev_n;
   logic                      ev_oe;
   logic                      ev_line;
   logic [16:0]               exp_q[$];
   logic [15:0]               v;
   logic [4:0]                r;
   int                        n_mismatch;
   int                        checks;
   int                        b;
   int                        j;
   int                        bits[4] = '{11, 8, 15, 14};
   logic [3:0]                tog[4] = '{4'h2, 4'h1, 4'h8, 4'h4};

   gpeio_top #(.PIN_N(5)) dut (.mclk(mclk), .reset(reset), .clk_en(clk_en),
      .cfg_req(req), .cfg_rdata(rdata), .cfg_rvalid(rvalid), .cfg_hit(hit),
      .src(src), .route(route), .multi_pin_in(pin_in),
      .multi_pin_out(pin_out), .multi_pin_oe(pin_oe),
      .general_event_out_n(ev_n), .general_event_oe(ev_oe));
   gpeio_pins_model u_pins (.ext_level(pin_lvl), .drv_val(pin_out),
      .drv_oe(pin_oe), .evt_n(ev_n), .evt_oe(ev_oe), .pin_level(pin_in),
      .evt_line(ev_line));

   always #12.5 mclk = ~mclk;

   task automatic check(string nm, logic [16:0] seen, logic [16:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done;
      if (n_mismatch == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // expectation is queued before the strobe is taken
   task automatic rd(logic [2:0] f, logic [7:0] a, logic [16:0] e);
      @(posedge mclk);
      req <= '{1'b1, 1'b0, f, a, 2'h3, 16'h0000};
      exp_q.push_back(e);
      @(posedge mclk);
      req <= '0;
   endtask

   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(posedge mclk);
      req <= '{1'b0, 1'b1, 3'h0, a, 2'h3, d};
      @(posedge mclk);
      req <= '0;
   endtask

   always @(posedge mclk)
      if (rvalid === 1'b1)
         check("cfg read", {hit, rdata}, exp_q.pop_front());

   initial
   begin
      #(25 * 4000);
      n_mismatch++;
      test_done;
   end

   initial
   begin
      mclk = 1'b0;
      reset = 1'b1;
      clk_en = 1'b1;
      req = '0;
      src = '0;
      route = '0;
      pin_lvl = 5'h00;
      n_mismatch = 0;
      checks = 0;
      v = 16'($urandom(10));
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      rd(3'h0, 8'hAA, 17'h10000);
      rd(3'h0, 8'hAE, 17'h10000);
      wr(8'hAA, 16'hFFFF);
      rd(3'h0, 8'hAA, 17'h1C91F);
      rd(3'h1, 8'hAA, 17'h00000);
      rd(3'h0, 8'hB0, 17'h00000);
      v = 16'($urandom());
      r = 5'($urandom());
      wr(8'hAE, v);
      route.output_role <= r;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check("pin drive", 17'(pin_out), 17'(v[4:0] & r));
      check("pin enable", 17'(pin_oe), 17'(r));
      rd(3'h0, 8'hAE, {1'b1, 11'h000, v[4:0]});
      route.output_role <= 5'h00;
      pin_lvl <= 5'($urandom());
      wr(8'hAC, 16'hFFFF);
      repeat (4) @(posedge mclk);
      rd(3'h0, 8'hAC, {1'b1, 11'h000, pin_lvl});
      route.input_role <= 5'h1F;
      route.event_route_any <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         j = $urandom_range(4);
         b = (k == 4) ? j : bits[k];
         wr(8'hA8, 16'hFFFF);
         repeat (2) @(posedge mclk);
         if (k == 4)
            pin_lvl[j] <= ~pin_lvl[j];
         else
            src <= src ^ tog[k];
         @(posedge mclk);
         // power and voltage sources are one-cycle pulses
         if (k < 2)
            src <= src ^ tog[k];
         repeat (6) @(negedge mclk);
         check("event low", 17'(ev_line), 17'h0);
         rd(3'h0, 8'hA8, 17'h10000 | (17'h1 << b));
         @(negedge mclk);
         check("event held", 17'(ev_line), 17'h0);
         wr(8'hA8, 16'h1 << b);
         repeat (3) @(negedge mclk);
         check("event clear", 17'(ev_line), 17'h1);
      end
      // terminals not set up as inputs must not raise status
      route.input_role <= 5'h00;
      pin_lvl <= ~pin_lvl;
      repeat (5) @(posedge mclk);
      rd(3'h0, 8'hA8, 17'h10000);
      wr(8'hAA, 16'h0000);
      src <= src ^ 4'h2;
      @(posedge mclk);
      src <= src ^ 4'h2;
      repeat (4) @(negedge mclk);
      check("event masked", 17'(ev_line), 17'h1);
      rd(3'h0, 8'hA8, 17'h10800);
      route.event_route_any <= 1'b0;
      wr(8'hAA, 16'hFFFF);
      repeat (3) @(negedge mclk);
      check("event idle", 17'({ev_oe, ev_line}), 17'h1);
      check("reads left", 17'(exp_q.size()), 17'h0);
      test_done;
   end
endmodule // tb_top
